//--- hdl/iep_consts.svh
// Functional notes
// R1: Enable bit passes request; resets cleared
// R2: Three-bit level, 111 is level 7
// R3: Level 001 lowest; 001-111 map directly
// R4: Level 000 never presents source pending
// R5: Each level field resets to 100
// R6: Unimplemented bits always read zero
// R7: Group 3: bits 14, 2, 1 only
// R8: Group 4: bits 13, 8, 3, 2, 1
// R9: Group 5: only bit 6
// R10: Level group 0: four fields 14-12 to 2-0
// R11: Level group 1: three fields, low nibble empty
// R12: Level group 2: four fields 14-12 to 2-0
// R13: Bits 15, 11, 7, 3 read zero
// R14: Forward when enabled, nonzero level; ignore unimplemented
`ifndef IEP_CONSTS_SVH
`define IEP_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IEP_OFS_EN3 8'h00
`define IEP_OFS_EN4 8'h04
`define IEP_OFS_EN5 8'h08
`define IEP_OFS_LV0 8'h0c
`define IEP_OFS_LV1 8'h10
`define IEP_OFS_LV2 8'h14
`define IEP_NUM_REGS 6

// ----------------------------------------
// Implemented bit masks
// ----------------------------------------
`define IEP_MASK_EN3 16'h4006
`define IEP_MASK_EN4 16'h210e
`define IEP_MASK_EN5 16'h0040
`define IEP_MASK_LV0 16'h7777
`define IEP_MASK_LV1 16'h7770
`define IEP_MASK_LV2 16'h7777

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IEP_RST_EN 16'h0000
`define IEP_RST_LV0 16'h4444
`define IEP_RST_LV1 16'h4440
`define IEP_RST_LV2 16'h4444

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IEP_FLD_HI 14
`define IEP_FLD_MH 10
`define IEP_FLD_ML 6
`define IEP_FLD_LO 2
`define IEP_NUM_EN 9
`define IEP_NUM_LV 11

// ----------------------------------------
// Enable bit positions
// ----------------------------------------
`define IEP_BIT_CLK_CAL 14
`define IEP_BIT_I2C_MST 2
`define IEP_BIT_I2C_SLV 1
`define IEP_BIT_CHARGE 13
`define IEP_BIT_LOWV 8
`define IEP_BIT_CRC 3
`define IEP_BIT_UART2_ERR 2
`define IEP_BIT_UART1_ERR 1
`define IEP_BIT_USB 6

`endif

//--- hdl/iep_pkg.sv
package iep_pkg;
    // Register word and level field types
    typedef logic [15:0] iep_word_type;
    typedef logic [2:0] iep_level_type;
endpackage : iep_pkg

//--- hdl/iep_regs.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "iep_consts.svh"

module iep_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw requests of enable-gated sources
    input wire logic [8:0] src_req_in,
    // Raw requests and outer enables of level sources
    input wire logic [10:0] lvl_req_in,
    input wire logic [10:0] lvl_en_in,
    // Gated and pending requests to the arbiter
    output logic [8:0] gated_req,
    output logic [10:0] lvl_pend,
    // Enable bits
    output logic calendar_clock_irq_en,
    output logic second_i2c_master_irq_en,
    output logic second_i2c_slave_irq_en,
    output logic charge_time_unit_irq_en,
    output logic low_voltage_detect_irq_en,
    output logic crc_engine_irq_en,
    output logic second_uart_error_irq_en,
    output logic first_uart_error_irq_en,
    output logic usb_otg_irq_en,
    // Level fields
    output logic [2:0] timer_one_irq_level,
    output logic [2:0] compare_one_irq_level,
    output logic [2:0] capture_one_irq_level,
    output logic [2:0] ext_pin_zero_irq_level,
    output logic [2:0] timer_two_irq_level,
    output logic [2:0] compare_two_irq_level,
    output logic [2:0] capture_two_irq_level,
    output logic [2:0] first_uart_rx_irq_level,
    output logic [2:0] first_spi_event_irq_level,
    output logic [2:0] first_spi_fault_irq_level,
    output logic [2:0] timer_three_irq_level
);

    // ----------------------------------------
    // Per-register tables
    // ----------------------------------------
    localparam iep_pkg::iep_word_type MASK [`IEP_NUM_REGS] = '{
        `IEP_MASK_EN3, `IEP_MASK_EN4, `IEP_MASK_EN5,
        `IEP_MASK_LV0, `IEP_MASK_LV1, `IEP_MASK_LV2};
    localparam iep_pkg::iep_word_type RSTV [`IEP_NUM_REGS] = '{
        `IEP_RST_EN, `IEP_RST_EN, `IEP_RST_EN,
        `IEP_RST_LV0, `IEP_RST_LV1, `IEP_RST_LV2};
    localparam logic [7:0] OFS [`IEP_NUM_REGS] = '{
        `IEP_OFS_EN3, `IEP_OFS_EN4, `IEP_OFS_EN5,
        `IEP_OFS_LV0, `IEP_OFS_LV1, `IEP_OFS_LV2};

    // ----------------------------------------
    // Storage and bus state
    // ----------------------------------------
    iep_pkg::iep_word_type reg_q [`IEP_NUM_REGS]; // Register words
    iep_pkg::iep_word_type reg_d [`IEP_NUM_REGS]; // Next words
    logic pready_q; // Access completes
    logic pslverr_q; // Unmapped access
    logic [31:0] prdata_q; // Read data
    logic [8:0] gated_q; // Gated requests
    logic [10:0] pend_q; // Pending level requests

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [`IEP_NUM_REGS-1:0] hit_w; // One-hot register hit
    logic mapped_w; // Any register hit
    logic access_w; // Access phase, waiting
    logic commit_w; // Transfer ends this edge
    logic wr_w; // Mapped write commits
    logic [15:0] lane_w; // Byte lane mask
    iep_pkg::iep_word_type rd_w; // Selected read word
    logic [8:0] en_w; // Enable bits
    iep_pkg::iep_level_type lvl_w [`IEP_NUM_LV]; // Level fields

    // Access phase before and at completion
    assign access_w = psel && penable && !pready_q;
    assign commit_w = psel && penable && pready_q;
    assign mapped_w = |hit_w;
    assign wr_w = commit_w && pwrite && mapped_w;
    assign lane_w = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    genvar k;
    generate
        for (k = 0; k < `IEP_NUM_REGS; k++)
        begin : g_reg
            // Address match for this word
            assign hit_w[k] = (paddr == OFS[k]);
            // Only implemented, strobed bits take the write
            assign reg_d[k] = (wr_w && hit_w[k])
                ? ((reg_q[k] & ~(lane_w & MASK[k])) |
                   (pwdata[15:0] & lane_w & MASK[k]))
                : reg_q[k]; // see R6 see R14

            // Register word, reset to its default
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    reg_q[k] <= RSTV[k]; // see R1 see R5
                else
                    reg_q[k] <= reg_d[k];
            end

            // Write of a word keeps only implemented bits
            wr_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
                (wr_w && hit_w[k] && pstrb[1:0] == 2'h3) |=>
                reg_q[k] == ($past(pwdata[15:0]) & MASK[k])) // see R14
                else $error("register write not masked to implemented bits");

            // Unimplemented bits stay zero
            spare_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
                (reg_q[k] & ~MASK[k]) == 16'h0000) // see R6 see R13
                else $error("unimplemented register bit not zero");
        end
    endgenerate

    // Read mux over the one-hot hit
    always_comb
    begin
        rd_w = 16'h0000;
        for (int i = 0; i < `IEP_NUM_REGS; i++)
        begin
            if (hit_w[i])
                rd_w = reg_q[i];
        end
    end

    // ----------------------------------------
    // APB answer, one wait state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= access_w;
            pslverr_q <= access_w && !mapped_w;
            // Upper half always zero
            prdata_q <= (access_w && !pwrite) ? {16'h0000, rd_w} : 32'h0000_0000; // see R6
        end
    end

    // Ready follows the first access cycle
    ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("ready not one cycle after access start");

    // Unmapped address reports an error
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_w && !mapped_w) |=> pslverr_q && pready_q)
        else $error("unmapped access without error");

    // Read data stands only in the ready cycle
    rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready_q |-> prdata_q == 32'h0000_0000) // see R6
        else $error("read data outside the answer cycle");

    // Upper half of read data never set
    rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        prdata_q[31:16] == 16'h0000) // see R6
        else $error("upper read data not zero");

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    // Enable group 3
    assign en_w[0] = reg_q[0][`IEP_BIT_CLK_CAL]; // see R7
    assign en_w[1] = reg_q[0][`IEP_BIT_I2C_MST]; // see R7
    assign en_w[2] = reg_q[0][`IEP_BIT_I2C_SLV]; // see R7
    // Enable group 4
    assign en_w[3] = reg_q[1][`IEP_BIT_CHARGE]; // see R8
    assign en_w[4] = reg_q[1][`IEP_BIT_LOWV]; // see R8
    assign en_w[5] = reg_q[1][`IEP_BIT_CRC]; // see R8
    assign en_w[6] = reg_q[1][`IEP_BIT_UART2_ERR]; // see R8
    assign en_w[7] = reg_q[1][`IEP_BIT_UART1_ERR]; // see R8
    // Enable group 5
    assign en_w[8] = reg_q[2][`IEP_BIT_USB]; // see R9

    // Level group 0
    assign lvl_w[0] = reg_q[3][`IEP_FLD_HI -: 3]; // see R10
    assign lvl_w[1] = reg_q[3][`IEP_FLD_MH -: 3]; // see R10
    assign lvl_w[2] = reg_q[3][`IEP_FLD_ML -: 3]; // see R10
    assign lvl_w[3] = reg_q[3][`IEP_FLD_LO -: 3]; // see R10
    // Level group 1, low nibble empty
    assign lvl_w[4] = reg_q[4][`IEP_FLD_HI -: 3]; // see R11
    assign lvl_w[5] = reg_q[4][`IEP_FLD_MH -: 3]; // see R11
    assign lvl_w[6] = reg_q[4][`IEP_FLD_ML -: 3]; // see R11
    // Level group 2
    assign lvl_w[7] = reg_q[5][`IEP_FLD_HI -: 3]; // see R12
    assign lvl_w[8] = reg_q[5][`IEP_FLD_MH -: 3]; // see R12
    assign lvl_w[9] = reg_q[5][`IEP_FLD_ML -: 3]; // see R12
    assign lvl_w[10] = reg_q[5][`IEP_FLD_LO -: 3]; // see R12

    // ----------------------------------------
    // Request gating
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gated_q <= 9'h000;
        else
            gated_q <= src_req_in & en_w; // see R1
    end

    generate
        for (k = 0; k < `IEP_NUM_LV; k++)
        begin : g_lvl
            // Pending needs outer enable and a nonzero level
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pend_q[k] <= 1'b0;
                else
                    pend_q[k] <= lvl_req_in[k] && lvl_en_in[k] &&
                        (lvl_w[k] != 3'h0); // see R2 see R3 see R4 see R14
            end

            // Level zero never shows pending
            off_level_a: assert property (@(posedge pclk) disable iff (!presetn)
                pend_q[k] |-> $past(lvl_w[k]) != 3'h0) // see R4
                else $error("source pending with level zero");

            // Any level 1 to 7 passes an enabled request
            live_level_a: assert property (@(posedge pclk) disable iff (!presetn)
                (lvl_req_in[k] && lvl_en_in[k] && lvl_w[k] inside {[3'h1:3'h7]})
                |=> pend_q[k]) // see R2 see R3
                else $error("enabled nonzero level not pending");

            // Pending needs the request and its outer enable
            pend_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
                pend_q[k] |-> $past(lvl_req_in[k] && lvl_en_in[k])) // see R14
                else $error("source pending without request and enable");
        end
    endgenerate

    // All enables cleared block every request
    en_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (en_w == 9'h000) |=> (gated_q == 9'h000)) // see R1
        else $error("request passed with enable cleared");

    // Each cleared enable bit blocks its own request
    gate_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (gated_q & ~$past(en_w)) == 9'h000) // see R1
        else $error("request passed its cleared enable bit");

    // Levels sit at 100 right after reset
    rst_level_a: assert property (@(posedge pclk)
        $rose(presetn) |-> (reg_q[3] == `IEP_RST_LV0 && reg_q[4] == `IEP_RST_LV1 &&
        reg_q[5] == `IEP_RST_LV2 && en_w == 9'h000)) // see R5 see R1
        else $error("reset values wrong");

    // Timer one field takes bits 14-12
    t1_field_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_w && hit_w[3] && pstrb[1]) |=>
        timer_one_irq_level == $past(pwdata[14:12])) // see R10 see R2
        else $error("timer one level field misplaced");

    // Group 5 enable follows bit 6
    usb_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_w && hit_w[2] && pstrb[0]) |=> usb_otg_irq_en == $past(pwdata[6])) // see R9
        else $error("usb enable not at bit 6");

    // ----------------------------------------
    // Outputs, all from flip-flops
    // ----------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gated_req = gated_q;
    assign lvl_pend = pend_q;
    assign calendar_clock_irq_en = en_w[0];
    assign second_i2c_master_irq_en = en_w[1];
    assign second_i2c_slave_irq_en = en_w[2];
    assign charge_time_unit_irq_en = en_w[3];
    assign low_voltage_detect_irq_en = en_w[4];
    assign crc_engine_irq_en = en_w[5];
    assign second_uart_error_irq_en = en_w[6];
    assign first_uart_error_irq_en = en_w[7];
    assign usb_otg_irq_en = en_w[8];
    assign timer_one_irq_level = lvl_w[0];
    assign compare_one_irq_level = lvl_w[1];
    assign capture_one_irq_level = lvl_w[2];
    assign ext_pin_zero_irq_level = lvl_w[3];
    assign timer_two_irq_level = lvl_w[4];
    assign compare_two_irq_level = lvl_w[5];
    assign capture_two_irq_level = lvl_w[6];
    assign first_uart_rx_irq_level = lvl_w[7];
    assign first_spi_event_irq_level = lvl_w[8];
    assign first_spi_fault_irq_level = lvl_w[9];
    assign timer_three_irq_level = lvl_w[10];

endmodule : iep_regs

//--- tb/iep_src_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Peripheral request sources
// ----------------------------------------
module iep_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Next pattern from the bench
    input wire logic [30:0] nxt_pat,
    // Raw requests and outer enables
    output logic [8:0] src_req,
    output logic [10:0] lvl_req,
    output logic [10:0] lvl_en
);
    // Requests are flop outputs held as levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {src_req, lvl_req, lvl_en} <= '0;
        end
        else
        begin
            {src_req, lvl_req, lvl_en} <= nxt_pat;
        end
    end
endmodule : iep_src_model

//--- tb/irq_enable_priority_regs_tb.sv
`timescale 1ns/1ps
`include "iep_consts.svh"

module irq_enable_priority_regs_tb;
    // Clock, reset and bus drive
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h3;
    logic [30:0] nxt_pat = '0;
    // Design outputs
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [8:0] src_req, gated_req, en;
    logic [10:0] lvl_req, lvl_en, lvl_pend;
    logic [32:0] lv;
    // Shadow registers and tables
    logic [15:0] sh [6];
    logic [15:0] msk [6] = '{`IEP_MASK_EN3, `IEP_MASK_EN4, `IEP_MASK_EN5,
        `IEP_MASK_LV0, `IEP_MASK_LV1, `IEP_MASK_LV2};
    logic [15:0] rstv [6] = '{`IEP_RST_EN, `IEP_RST_EN, `IEP_RST_EN,
        `IEP_RST_LV0, `IEP_RST_LV1, `IEP_RST_LV2};
    logic [15:0] pats [4] = '{16'hffff, 16'h0000, 16'h1111, 16'h7777};
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int compares = 0;

    // Clock of 8 ns
    always #4 pclk = ~pclk;

    iep_src_model src (.pclk(pclk), .presetn(presetn), .nxt_pat(nxt_pat),
        .src_req(src_req), .lvl_req(lvl_req), .lvl_en(lvl_en));

    iep_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req_in(src_req), .lvl_req_in(lvl_req), .lvl_en_in(lvl_en),
        .gated_req(gated_req), .lvl_pend(lvl_pend),
        .calendar_clock_irq_en(en[0]), .second_i2c_master_irq_en(en[1]),
        .second_i2c_slave_irq_en(en[2]), .charge_time_unit_irq_en(en[3]),
        .low_voltage_detect_irq_en(en[4]), .crc_engine_irq_en(en[5]),
        .second_uart_error_irq_en(en[6]), .first_uart_error_irq_en(en[7]),
        .usb_otg_irq_en(en[8]), .timer_one_irq_level(lv[2:0]),
        .compare_one_irq_level(lv[5:3]), .capture_one_irq_level(lv[8:6]),
        .ext_pin_zero_irq_level(lv[11:9]), .timer_two_irq_level(lv[14:12]),
        .compare_two_irq_level(lv[17:15]), .capture_two_irq_level(lv[20:18]),
        .first_uart_rx_irq_level(lv[23:21]), .first_spi_event_irq_level(lv[26:24]),
        .first_spi_fault_irq_level(lv[29:27]), .timer_three_irq_level(lv[32:30]));

    // Verdict and end of run
    task automatic close_out();
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Value comparison
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Expected level of source i from the shadow
    function automatic logic [2:0] lvf(input int i);
        int r;
        int b;
        r = i < 4 ? 3 : (i < 7 ? 4 : 5);
        b = i < 4 ? i : (i < 7 ? i - 4 : i - 7);
        return sh[r][12 - 4 * b +: 3];
    endfunction : lvf

    // Expected enable vector in source order
    function automatic logic [8:0] ex_en();
        return {sh[2][6], sh[1][1], sh[1][2], sh[1][3], sh[1][8], sh[1][13],
            sh[0][1], sh[0][2], sh[0][14]};
    endfunction : ex_en

    // One APB transfer with idle edge before it; checks answer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] s);
        int n;
        int i;
        logic map;
        logic [15:0] bm;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'($urandom), d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        map = (a < 8'h18) && (a[1:0] == 2'b00);
        i = map ? int'(a >> 2) : 0;
        bm = {{8{s[1]}}, {8{s[0]}}};
        chk("pslverr", {63'h0, !map}, {63'h0, err});
        if (wr && map)
            sh[i] = ((sh[i] & ~bm) | (d & bm)) & msk[i];
        if (!wr)
            chk("prdata", map ? {48'h0, sh[i]} : 64'h0, {32'h0, rd});
    endtask : apb

    // Output fields and request gating after a fresh pattern
    task automatic out_chk();
        logic [10:0] ep;
        nxt_pat <= 31'($urandom);
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 11; i++)
            ep[i] = lvl_req[i] & lvl_en[i] & (lvf(i) != 3'b000);
        chk("enables", {55'h0, ex_en()}, {55'h0, en});
        for (int i = 0; i < 11; i++)
            chk("level", {61'h0, lvf(i)}, {61'h0, lv[3 * i +: 3]});
        chk("gated_req", {55'h0, src_req & ex_en()}, {55'h0, gated_req});
        chk("lvl_pend", {53'h0, ep}, {53'h0, lvl_pend});
    endtask : out_chk

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h8fdf));
        sh = rstv;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register
        out_chk();
        for (int r = 0; r < 6; r++)
            apb(1'b0, 8'(r * 4), 16'h0, 4'h3);
        // Corner patterns into every register
        foreach (pats[p])
            for (int r = 0; r < 6; r++)
            begin
                apb(1'b1, 8'(r * 4), pats[p], 4'h3);
                apb(1'b0, 8'(r * 4), 16'h0, 4'h3);
                out_chk();
            end
        // Random traffic, strobes and unmapped places
        repeat (40)
        begin
            apb(1'b1, 8'($urandom_range(0, 7) * 4), 16'($urandom), 4'($urandom));
            apb(1'b0, 8'($urandom_range(0, 7) * 4), 16'h0, 4'h3);
            apb(1'b1, 8'h02, 16'hffff, 4'h3);
            out_chk();
        end
        // Second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        sh = rstv;
        @(posedge pclk);
        presetn <= 1'b1;
        out_chk();
        for (int r = 0; r < 6; r++)
            apb(1'b0, 8'(r * 4), 16'h0, 4'h3);
        close_out();
    end
endmodule : irq_enable_priority_regs_tb
